//--- shared/smop_regs.svh
// Opcodes, register offsets, field positions, reset values and counts
`ifndef SMOP_REGS_SVH
`define SMOP_REGS_SVH

`define SMOP_OP_GET_MASK      8'hF8
`define SMOP_OP_GET_BASE      8'h20
`define SMOP_OP_X_INC         8'h0F
`define SMOP_OP_B_INC         8'h13
`define SMOP_OP_IRQ_BLOCK     8'h1D
`define SMOP_OP_IRQ_ALLOW     8'h1E
`define SMOP_OP_SIGN_FILL     8'h29
`define SMOP_OP_ZERO_FILL     8'h2A
`define SMOP_OP_OFFCHIP       8'h2B
`define SMOP_OP_ONCHIP        8'h2C
`define SMOP_OP_LOOKUP_ACC    8'h58
`define SMOP_OP_SPEECH_LOAD   8'h59
`define SMOP_OP_RAM_INC       8'h5E

`define SMOP_REG_SPEECH_ADDR  4'h0
`define SMOP_REG_STATE        4'h4
`define SMOP_REG_ACC          4'h8
`define SMOP_REG_BXM          4'hC

`define SMOP_ST_CNT_LSB       0
`define SMOP_ST_SF            4
`define SMOP_ST_OFFCHIP       5
`define SMOP_ST_SIGN          6
`define SMOP_ST_INTERP        7
`define SMOP_ST_IRQ_EN        8
`define SMOP_ST_PEND          9
`define SMOP_ST_BUSY          10

`define SMOP_RST_SA           14'h0000
`define SMOP_RST_TIMER        8'hFF
`define SMOP_BYTE_MAX         8'hFF
`define SMOP_PS_FULL          4'h8
`define SMOP_EXT_SAMPLE       4'hF
`define SMOP_OE_ONCHIP        8'hFF
`define SMOP_OE_OFFCHIP       8'h7E

`endif

//--- shared/smop_pkg.sv
// Types shared by the instruction subset block
package smop_pkg;

	typedef enum logic [2:0] {
		SMOP_IDLE   = 3'b001,
		SMOP_EXEC   = 3'b010,
		SMOP_RELOAD = 3'b100
	} smop_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} smop_reg_req_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} smop_pins_t;

endpackage : smop_pkg

//--- rtl/smop_pc_stack.sv
// Program counter stack, newest entry on top, bottom lost on overflow
`timescale 1ns/1ps
`include "smop_regs.svh"
module smop_pc_stack
	import smop_pkg::*;
#(
	parameter int PC_W  = 14,
	parameter int DEPTH = 5
) (
	input  wire logic                         core_clk,
	input  wire logic                         reset_n,
	input  wire logic                         push,
	input  wire logic                         pop,
	input  wire logic [PC_W-1:0]              push_pc,
	output logic      [PC_W-1:0]              top_pc,
	output logic      [$clog2(DEPTH+1)-1:0]   level
);
	localparam int LW = $clog2(DEPTH + 1);

	logic [PC_W-1:0] entry_q [DEPTH];
	logic [LW-1:0]   level_q;

	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		always_ff @(posedge core_clk) begin
			if (!reset_n) begin
				entry_q[g] <= '0;
			end else if (push) begin
				if (g == 0) begin
					entry_q[g] <= push_pc;
				end else begin
					entry_q[g] <= entry_q[(g > 0) ? g - 1 : 0];
				end
			end else if (pop) begin
				if (g == DEPTH - 1) begin
					entry_q[g] <= '0;
				end else begin
					entry_q[g] <= entry_q[(g < DEPTH - 1) ? g + 1 : g];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			level_q <= '0;
		end else if (push && level_q != LW'(DEPTH)) begin
			level_q <= level_q + LW'(1);
		end else if (pop && !push && level_q != '0) begin
			level_q <= level_q - LW'(1);
		end
	end

	assign top_pc = entry_q[0];
	assign level  = level_q;

endmodule : smop_pc_stack

//--- rtl/smop_exec.sv
// Executes the bit-fetch, lookup, increment, interrupt and mode instructions
// Notes on behaviour
// - Fetch beyond remaining bits reloads in third cycle
// - Source mode selects offchip or onchip fetch data
// - Fetch pushes then pops; full stack loses bottom
// - B increment; flag only on FF wrap
// - RAM at X increment; flag on FF wrap
// - Block op masks timer only; timer keeps counting
// - Timer wrap sets pending, leaves FF, stays pending
// - Allow op enables timer interrupt and one-frame interpolation
// - Zero fill mode clears upper two ALU bits
// - Onchip source drives all port B pins
// - X increment; flag only on FF wrap
// - Lookup loads accumulator from ROM at accumulator
// - Five-level stack; fetch and lookups pop before done
// - Speech load fills register, bumps address, count eight
// - Fetch shifts register LSB into accumulator LSB
// - Offchip source: clock/16 on six, data in seven
// - Sign fill mode copies bit seven upward
`timescale 1ns/1ps
`include "smop_regs.svh"
module smop_exec
	import smop_pkg::*;
#(
	parameter int PC_W        = 14,
	parameter int SA_W        = 14,
	parameter int RAM_DEPTH   = 256,
	parameter int STACK_DEPTH = 5
) (
	input  wire logic                               core_clk,
	input  wire logic                               reset_n,
	input  wire logic                               op_valid,
	input  wire logic          [7:0]                op_code,
	output logic                                    op_ready,
	output logic                                    op_done,
	input  wire logic          [PC_W-1:0]           pc_in,
	input  wire logic                               call_push,
	input  wire logic                               ret_pop,
	output logic               [PC_W-1:0]           stack_top,
	output logic               [$clog2(STACK_DEPTH+1)-1:0] stack_level,
	output logic                                    irq_take,
	input  wire logic                               timer_tick,
	input  wire logic                               timer_load,
	input  wire logic          [7:0]                timer_load_val,
	output logic               [7:0]                timer_value,
	input  wire logic                               frame_end,
	output logic                                    interp_en,
	input  wire logic          [7:0]                alu_operand,
	output logic               [9:0]                alu_operand_ext,
	output logic                                    sign_fill,
	output logic               [9:0]                acc,
	output logic               [7:0]                b_reg,
	output logic               [7:0]                x_reg,
	output logic                                    status_flag,
	output logic               [SA_W-1:0]           rom_addr,
	input  wire logic          [7:0]                rom_data,
	input  wire smop_reg_req_t                      reg_req,
	output logic               [31:0]               reg_rdata,
	input  wire logic          [7:0]                port_b_data,
	input  wire logic          [7:0]                port_b_in,
	output smop_pins_t                              port_b_pins
);
	localparam int RAM_AW = $clog2(RAM_DEPTH);

	smop_state_t     state_q;
	smop_state_t     state_d;
	logic [7:0]      op_q;
	logic [9:0]      acc_q;
	logic [7:0]      ps_q;
	logic [3:0]      cnt_q;
	logic [3:0]      rem_q;
	logic [SA_W-1:0] sa_q;
	logic [SA_W-1:0] rom_addr_q;
	logic [7:0]      b_q;
	logic [7:0]      x_q;
	logic [7:0]      ram_q [RAM_DEPTH];
	logic            sf_q;
	logic            irq_en_q;
	logic            pend_q;
	logic            interp_q;
	logic            sign_q;
	logic [9:0]      opnd_q;
	logic [7:0]      timer_q;
	logic            offchip_q;
	logic [3:0]      div_q;
	logic [2:0]      rd_sync_q;
	logic            rd_filt_q;
	logic [7:0]      ext_sh_q;
	logic [2:0]      ext_cnt_q;
	logic [7:0]      ext_byte_q;
	logic            done_q;
	logic [31:0]     rdata_q;
	logic            accept;
	logic            accept_multi;
	logic            accept_single;
	logic            fin;
	logic            need_reload;
	logic [3:0]      get_n;
	logic [7:0]      ram_x;
	logic [7:0]      new_byte;
	logic            stk_push;
	logic            stk_pop;
	logic            timer_wrap;

	function automatic logic is_get(input logic [7:0] op);
		return (op & `SMOP_OP_GET_MASK) == `SMOP_OP_GET_BASE;
	endfunction : is_get

	function automatic logic is_multi(input logic [7:0] op);
		return is_get(op) || op == `SMOP_OP_LOOKUP_ACC || op == `SMOP_OP_SPEECH_LOAD;
	endfunction : is_multi

	// Moves n bits from the low end of p into the low end of a
	function automatic logic [17:0] shift_bits(input logic [9:0] a, input logic [7:0] p,
	                                           input logic [3:0] n);
		logic [9:0] ta;
		logic [7:0] tp;
		ta = a;
		tp = p;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n) begin
				ta = {ta[8:0], tp[0]};
				tp = {1'b0, tp[7:1]};
			end
		end
		return {ta, tp};
	endfunction : shift_bits

	// Sequencing
	assign op_ready      = (state_q == SMOP_IDLE);
	assign accept        = op_ready && op_valid;
	assign accept_multi  = accept && is_multi(op_code);
	assign accept_single = accept && !is_multi(op_code);
	assign get_n         = {1'b0, op_q[2:0]} + 4'h1;
	assign need_reload   = is_get(op_q) && (get_n > cnt_q);
	assign fin           = (state_q == SMOP_EXEC && !need_reload) || state_q == SMOP_RELOAD;
	assign ram_x         = ram_q[x_q[RAM_AW-1:0]];
	assign new_byte      = offchip_q ? ext_byte_q : rom_data;

	always_comb begin
		state_d = state_q;
		case (state_q)
			SMOP_IDLE: begin
				if (accept_multi) begin
					state_d = SMOP_EXEC;
				end
			end
			SMOP_EXEC: begin
				state_d = need_reload ? SMOP_RELOAD : SMOP_IDLE;
			end
			SMOP_RELOAD: begin
				state_d = SMOP_IDLE;
			end
			default: begin
				state_d = SMOP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_q <= SMOP_IDLE;
			op_q    <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= accept_single || fin;
			if (accept) begin
				op_q <= op_code;
			end
		end
	end

	// Stack traffic: fetch and lookups push on accept and pop on their last cycle
	assign stk_push = accept_multi || irq_take || call_push;
	assign stk_pop  = fin || ret_pop;

	smop_pc_stack #(
		.PC_W  (PC_W),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.push     (stk_push),
		.pop      (stk_pop),
		.push_pc  (pc_in),
		.top_pc   (stack_top),
		.level    (stack_level)
	);

	// Accumulator, parallel-to-serial register, bit count and speech address
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			acc_q      <= '0;
			ps_q       <= '0;
			cnt_q      <= '0;
			rem_q      <= '0;
			sa_q       <= `SMOP_RST_SA;
			rom_addr_q <= `SMOP_RST_SA;
		end else begin
			if (accept_multi) begin
				rom_addr_q <= (op_code == `SMOP_OP_LOOKUP_ACC) ?
				              {{(SA_W - 10){1'b0}}, acc_q} : sa_q;
			end
			if (state_q == SMOP_EXEC && is_get(op_q)) begin
				if (!need_reload) begin
					{acc_q, ps_q} <= shift_bits(acc_q, ps_q, get_n);
					cnt_q         <= cnt_q - get_n;
				end else begin
					{acc_q, ps_q} <= shift_bits(acc_q, ps_q, cnt_q);
					rem_q         <= get_n - cnt_q;
				end
			end else if (state_q == SMOP_EXEC && op_q == `SMOP_OP_LOOKUP_ACC) begin
				acc_q <= {2'b00, rom_data};
			end else if (state_q == SMOP_EXEC && op_q == `SMOP_OP_SPEECH_LOAD) begin
				ps_q  <= rom_data;
				cnt_q <= `SMOP_PS_FULL;
			end else if (state_q == SMOP_RELOAD) begin
				{acc_q, ps_q} <= shift_bits(acc_q, new_byte, rem_q);
				cnt_q         <= `SMOP_PS_FULL - rem_q;
			end
			if (reg_req.wr && reg_req.addr == `SMOP_REG_SPEECH_ADDR) begin
				sa_q <= reg_req.wdata[SA_W-1:0];
			end else if (state_q == SMOP_EXEC && op_q == `SMOP_OP_SPEECH_LOAD) begin
				sa_q <= sa_q + SA_W'(1);
			end else if (state_q == SMOP_RELOAD && !offchip_q) begin
				sa_q <= sa_q + SA_W'(1);
			end
		end
	end

	// B, X, RAM increments and the status flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			b_q  <= '0;
			x_q  <= '0;
			sf_q <= 1'b0;
		end else begin
			if (accept_single) begin
				case (op_code)
					`SMOP_OP_B_INC: begin
						b_q  <= b_q + 8'h01;
						sf_q <= (b_q == `SMOP_BYTE_MAX);
					end
					`SMOP_OP_X_INC: begin
						x_q  <= x_q + 8'h01;
						sf_q <= (x_q == `SMOP_BYTE_MAX);
					end
					`SMOP_OP_RAM_INC: begin
						sf_q <= (ram_x == `SMOP_BYTE_MAX);
					end
					default: begin
						sf_q <= 1'b1;
					end
				endcase
			end else if (fin) begin
				sf_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			for (int r = 0; r < RAM_DEPTH; r++) begin
				ram_q[r] <= 8'h00;
			end
		end else if (accept_single && op_code == `SMOP_OP_RAM_INC) begin
			ram_q[x_q[RAM_AW-1:0]] <= ram_x + 8'h01;
		end
	end

	// Timer and its interrupt
	assign timer_wrap = timer_tick && !timer_load && timer_q == 8'h00;
	assign irq_take   = pend_q && irq_en_q && op_ready && !op_valid;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			timer_q <= `SMOP_RST_TIMER;
		end else if (timer_load) begin
			timer_q <= timer_load_val;
		end else if (timer_tick) begin
			timer_q <= timer_q - 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pend_q   <= 1'b0;
			irq_en_q <= 1'b0;
			interp_q <= 1'b0;
		end else begin
			if (timer_wrap) begin
				pend_q <= 1'b1;
			end else if (irq_take) begin
				pend_q <= 1'b0;
			end
			if (accept_single && op_code == `SMOP_OP_IRQ_BLOCK) begin
				irq_en_q <= 1'b0;
			end else if (accept_single && op_code == `SMOP_OP_IRQ_ALLOW) begin
				irq_en_q <= 1'b1;
			end
			if (accept_single && op_code == `SMOP_OP_IRQ_ALLOW) begin
				interp_q <= 1'b1;
			end else if (frame_end) begin
				interp_q <= 1'b0;
			end
		end
	end

	// ALU fill mode
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sign_q <= 1'b0;
			opnd_q <= '0;
		end else begin
			if (accept_single && op_code == `SMOP_OP_ZERO_FILL) begin
				sign_q <= 1'b0;
			end else if (accept_single && op_code == `SMOP_OP_SIGN_FILL) begin
				sign_q <= 1'b1;
			end
			opnd_q <= sign_q ? {{2{alu_operand[7]}}, alu_operand}
			                 : {2'b00, alu_operand};
		end
	end

	// ROM source and port B pin roles
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			offchip_q <= 1'b0;
		end else if (accept_single && op_code == `SMOP_OP_OFFCHIP) begin
			offchip_q <= 1'b1;
		end else if (accept_single && op_code == `SMOP_OP_ONCHIP) begin
			offchip_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	always_comb begin
		port_b_pins.out = port_b_data;
		port_b_pins.oe  = `SMOP_OE_ONCHIP;
		if (offchip_q) begin
			port_b_pins.out[6] = div_q[3];
			port_b_pins.oe     = `SMOP_OE_OFFCHIP;
		end
	end

	// Serial ROM data: three-stage sync, accepted when the last two agree
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rd_sync_q <= '0;
			rd_filt_q <= 1'b0;
		end else begin
			rd_sync_q <= {rd_sync_q[1:0], port_b_in[7]};
			if (rd_sync_q[1] == rd_sync_q[2]) begin
				rd_filt_q <= rd_sync_q[2];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ext_sh_q   <= '0;
			ext_cnt_q  <= '0;
			ext_byte_q <= '0;
		end else if (!offchip_q) begin
			ext_cnt_q <= '0;
		end else if (div_q == `SMOP_EXT_SAMPLE) begin
			ext_sh_q  <= {rd_filt_q, ext_sh_q[7:1]};
			ext_cnt_q <= ext_cnt_q + 3'h1;
			if (ext_cnt_q == 3'h7) begin
				ext_byte_q <= {rd_filt_q, ext_sh_q[7:1]};
			end
		end
	end

	// Register port, read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (reg_req.rd) begin
			rdata_q <= '0;
			case (reg_req.addr)
				`SMOP_REG_SPEECH_ADDR: rdata_q[SA_W-1:0] <= sa_q;
				`SMOP_REG_STATE: begin
					rdata_q[`SMOP_ST_CNT_LSB+:4] <= cnt_q;
					rdata_q[`SMOP_ST_SF]         <= sf_q;
					rdata_q[`SMOP_ST_OFFCHIP]    <= offchip_q;
					rdata_q[`SMOP_ST_SIGN]       <= sign_q;
					rdata_q[`SMOP_ST_INTERP]     <= interp_q;
					rdata_q[`SMOP_ST_IRQ_EN]     <= irq_en_q;
					rdata_q[`SMOP_ST_PEND]       <= pend_q;
					rdata_q[`SMOP_ST_BUSY]       <= !op_ready;
				end
				`SMOP_REG_ACC: rdata_q[9:0]   <= acc_q;
				`SMOP_REG_BXM: rdata_q[23:0]  <= {ram_x, b_q, x_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign op_done         = done_q;
	assign reg_rdata       = rdata_q;
	assign timer_value     = timer_q;
	assign interp_en       = interp_q;
	assign alu_operand_ext = opnd_q;
	assign sign_fill       = sign_q;
	assign acc             = acc_q;
	assign b_reg           = b_q;
	assign x_reg           = x_q;
	assign status_flag     = sf_q;
	assign rom_addr        = rom_addr_q;

endmodule : smop_exec

//--- testbench/smop_exec_properties.sv
// Port-level checks for the instruction subset block
`timescale 1ns/1ps
module smop_exec_properties
	import smop_pkg::*;
#(
	parameter int SA_W        = 14,
	parameter int STACK_DEPTH = 5
) (
	input wire logic                             core_clk,
	input wire logic                             reset_n,
	input wire logic                             op_valid,
	input wire logic [7:0]                       op_code,
	input wire logic                             op_ready,
	input wire logic                             op_done,
	input wire logic [$clog2(STACK_DEPTH+1)-1:0] stack_level,
	input wire logic                             timer_tick,
	input wire logic                             timer_load,
	input wire logic [7:0]                       timer_value,
	input wire logic                             interp_en,
	input wire logic [7:0]                       alu_operand,
	input wire logic [9:0]                       alu_operand_ext,
	input wire logic                             sign_fill,
	input wire logic [9:0]                       acc,
	input wire logic [7:0]                       b_reg,
	input wire logic [7:0]                       x_reg,
	input wire logic                             status_flag,
	input wire logic [SA_W-1:0]                  rom_addr,
	input wire smop_pins_t                       port_b_pins
);
	logic [7:0]                       op_q;
	logic [7:0]                       b_q;
	logic [7:0]                       x_q;
	logic [$clog2(STACK_DEPTH+1)-1:0] lv_q;
	logic [9:0]                       ext_q;
	// Snapshot of the operands at the accepting edge
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			op_q <= 8'h00;
		end else if (op_valid && op_ready) begin
			op_q <= op_code;
			b_q  <= b_reg;
			x_q  <= x_reg;
			lv_q <= stack_level;
		end
	end
	always_ff @(posedge core_clk) begin
		ext_q <= sign_fill ? {{2{alu_operand[7]}}, alu_operand} : {2'b00, alu_operand};
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_B_INC: assert property (
		op_done && op_q == 8'h13 |-> b_reg == b_q + 8'h01 && status_flag == (b_q == 8'hFF))
		else $error("B increment wrong");
	AST_X_INC: assert property (
		op_done && op_q == 8'h0F |-> x_reg == x_q + 8'h01 && status_flag == (x_q == 8'hFF))
		else $error("X increment wrong");
	AST_LOOKUP_ADDR: assert property (
		op_valid && op_ready && op_code == 8'h58 |=> rom_addr == SA_W'($past(acc)))
		else $error("lookup address wrong");
	AST_LOOKUP_FILL: assert property (
		op_done && op_q == 8'h58 |-> acc[9:8] == 2'b00)
		else $error("lookup upper bits set");
	AST_STACK_KEEP: assert property (
		op_done && op_q[7:3] == 5'b00100 |-> stack_level == ((lv_q == STACK_DEPTH) ? lv_q - 1 : lv_q))
		else $error("fetch left stack depth wrong");
	AST_PINS: assert property (
		op_done && (op_q == 8'h2B || op_q == 8'h2C)
		|-> port_b_pins.oe == ((op_q == 8'h2B) ? 8'h7E : 8'hFF))
		else $error("port B direction wrong");
	AST_FILL_MODE: assert property (
		op_done && (op_q == 8'h29 || op_q == 8'h2A) |-> sign_fill == (op_q == 8'h29))
		else $error("fill mode wrong");
	AST_FILL_EXT: assert property (
		$past(reset_n) |-> alu_operand_ext == ext_q)
		else $error("operand extension wrong");
	AST_TIMER_DEC: assert property (
		timer_tick && !timer_load && timer_value != 8'h00
		|=> timer_value == $past(timer_value) - 8'h01)
		else $error("timer did not decrement");
	AST_TIMER_WRAP: assert property (
		timer_tick && !timer_load && timer_value == 8'h00 |=> timer_value == 8'hFF)
		else $error("timer not left at FF");
	AST_INTERP: assert property (
		op_done && op_q == 8'h1E |-> interp_en)
		else $error("interpolation not enabled");
endmodule : smop_exec_properties

bind smop_exec smop_exec_properties #(.SA_W(SA_W), .STACK_DEPTH(STACK_DEPTH)) smop_exec_properties_i (
	.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
	.op_ready(op_ready), .op_done(op_done), .stack_level(stack_level),
	.timer_tick(timer_tick), .timer_load(timer_load), .timer_value(timer_value),
	.interp_en(interp_en), .alu_operand(alu_operand), .alu_operand_ext(alu_operand_ext),
	.sign_fill(sign_fill), .acc(acc), .b_reg(b_reg), .x_reg(x_reg),
	.status_flag(status_flag), .rom_addr(rom_addr), .port_b_pins(port_b_pins)
);

//--- testbench/smop_rom_model.sv
// On-chip ROM and external serial ROM model
`timescale 1ns/1ps
module smop_rom_model
	import smop_pkg::*;
#(
	parameter int         SA_W     = 14,
	parameter logic [7:0] EXT_BYTE = 8'hFF
) (
	input wire logic            core_clk,
	input wire logic [SA_W-1:0] rom_addr,
	output logic     [7:0]      rom_data,
	input wire smop_pins_t      port_b_pins,
	input wire logic            ser_en,
	output logic                ser_bit
);
	logic [7:0] sh_q = EXT_BYTE;
	logic       last_q = 1'b0;
	// Byte follows the registered address, valid the cycle after it is set
	assign rom_data = rom_addr[7:0] ^ 8'h5A;
	// Serial data advances LSB first on each ROM clock rise
	always @(posedge port_b_pins.out[6]) begin
		sh_q <= {sh_q[0], sh_q[7:1]};
	end
	always @(posedge core_clk) begin
		if (ser_en) begin
			last_q <= sh_q[0];
		end
	end
	// Released output shows the inverse of its last value
	assign ser_bit = ser_en ? sh_q[0] : ~last_q;
endmodule : smop_rom_model

//--- testbench/smop_exec_tb_top.sv
// Self-checking bench for the instruction subset block
`timescale 1ns/1ps
`define SMOP_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module smop_exec_tb_top
	import smop_pkg::*;
;
	logic          core_clk = 1'b0;
	logic          reset_n = 1'b0;
	logic          op_valid = 1'b0;
	logic [7:0]    op_code = 8'h00;
	logic [13:0]   pc_in = 14'h0000;
	logic          call_push = 1'b0;
	logic          ret_pop = 1'b0;
	logic          timer_tick = 1'b0;
	logic          timer_load = 1'b0;
	logic [7:0]    timer_load_val = 8'h00;
	logic          frame_end = 1'b0;
	logic [7:0]    alu_operand = 8'h00;
	logic [7:0]    port_b_data = 8'h00;
	logic          ser_en = 1'b1;
	smop_reg_req_t reg_req = '0;
	logic          op_ready, op_done, irq_take, interp_en, sign_fill, status_flag, ser_bit;
	logic [13:0]   stack_top, rom_addr;
	logic [2:0]    stack_level;
	logic [7:0]    timer_value, b_reg, x_reg, rom_data, port_b_in;
	logic [9:0]    alu_operand_ext, acc, ea;
	logic [31:0]   reg_rdata, rd;
	smop_pins_t    port_b_pins;
	logic          irq_seen = 1'b0;
	logic          p6_q = 1'b0;
	int            n_fail = 0;
	int            checks_done = 0;
	int            cyc, base, i, pe6;

	always #20 core_clk = ~core_clk;
	assign port_b_in = (port_b_pins.oe & port_b_pins.out) | (~port_b_pins.oe & {ser_bit, 7'h7F});
	always @(negedge core_clk) begin
		if (irq_take === 1'b1) irq_seen <= 1'b1;
		if (port_b_pins.out[6] === 1'b1 && p6_q === 1'b0) pe6++;
		p6_q <= port_b_pins.out[6];
	end

	smop_exec smop_exec_i (
		.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
		.op_ready(op_ready), .op_done(op_done), .pc_in(pc_in), .call_push(call_push),
		.ret_pop(ret_pop), .stack_top(stack_top), .stack_level(stack_level),
		.irq_take(irq_take), .timer_tick(timer_tick), .timer_load(timer_load),
		.timer_load_val(timer_load_val), .timer_value(timer_value), .frame_end(frame_end),
		.interp_en(interp_en), .alu_operand(alu_operand), .alu_operand_ext(alu_operand_ext),
		.sign_fill(sign_fill), .acc(acc), .b_reg(b_reg), .x_reg(x_reg),
		.status_flag(status_flag), .rom_addr(rom_addr), .rom_data(rom_data),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .port_b_data(port_b_data),
		.port_b_in(port_b_in), .port_b_pins(port_b_pins)
	);
	smop_rom_model smop_rom_model_i (
		.core_clk(core_clk), .rom_addr(rom_addr), .rom_data(rom_data),
		.port_b_pins(port_b_pins), .ser_en(ser_en), .ser_bit(ser_bit)
	);

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task op(input logic [7:0] c);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_code  <= c;
		do @(negedge core_clk); while (op_ready !== 1'b1);
		@(posedge core_clk);
		op_valid <= 1'b0;
		cyc = 0;
		do begin @(negedge core_clk); cyc++; end while (op_done !== 1'b1 && cyc < 20);
		`SMOP_CHK("done", 1'b1, op_done)
	endtask : op
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req <= '0;
	endtask : wr
	task rdr(input logic [3:0] a);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		@(negedge core_clk);
		rd = reg_rdata;
	endtask : rdr
	task strobe(input int n, input int k);
		for (int j = 0; j < n; j++) begin
			@(posedge core_clk);
			call_push <= (k == 0);
			ret_pop   <= (k == 1);
			timer_tick <= (k == 2);
			pc_in     <= 14'h0100 + 14'(j);
		end
		@(posedge core_clk);
		{call_push, ret_pop, timer_tick} <= 3'b000;
		@(negedge core_clk);
	endtask : strobe
	function automatic logic [9:0] shin(logic [9:0] a, logic [7:0] p, int lo, int n);
		for (int k = lo; k < lo + n; k++) a = {a[8:0], p[k]};
		return a;
	endfunction : shin

	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		wr(4'h0, 32'h0000_0010);
		op(8'h59);
		base = cyc;
		rdr(4'h0);
		`SMOP_CHK("sa", 32'h0000_0011, rd)
		rdr(4'h4);
		`SMOP_CHK("cnt", 4'h8, rd[3:0])
		op(8'h24);
		ea = shin(10'h000, 8'h4A, 0, 5);
		`SMOP_CHK("get5", ea, acc)
		`SMOP_CHK("get5 cyc", base, cyc)
		op(8'h25);
		ea = shin(shin(ea, 8'h4A, 5, 3), 8'h4B, 0, 3);
		`SMOP_CHK("get6", ea, acc)
		`SMOP_CHK("get6 cyc", base + 1, cyc)
		rdr(4'h4);
		`SMOP_CHK("cnt", 4'h5, rd[3:0])
		op(8'h58);
		ea = {2'b00, ea[7:0] ^ 8'h5A};
		`SMOP_CHK("lookup", ea, acc)
		strobe(5, 0);
		op(8'h20);
		`SMOP_CHK("level", 3'd4, stack_level)
		`SMOP_CHK("top", 14'h0104, stack_top)
		strobe(4, 1);
		for (i = 0; i < 256; i++) begin
			op(8'h13);
			`SMOP_CHK("b", 8'(i + 1), b_reg)
			`SMOP_CHK("b sf", (i == 255), status_flag)
			op(8'h0F);
			`SMOP_CHK("x sf", (i == 255), status_flag)
		end
		for (i = 0; i < 256; i++) begin
			op(8'h5E);
			`SMOP_CHK("m sf", (i == 255), status_flag)
		end
		rdr(4'hC);
		`SMOP_CHK("mem", 24'h00_0000, rd[23:0])
		op(8'h1D);
		@(posedge core_clk);
		timer_load <= 1'b1;
		timer_load_val <= 8'h02;
		@(posedge core_clk);
		timer_load <= 1'b0;
		strobe(3, 2);
		`SMOP_CHK("timer", 8'hFF, timer_value)
		rdr(4'h4);
		`SMOP_CHK("pend", 1'b1, rd[9])
		`SMOP_CHK("no irq", 1'b0, irq_seen)
		op(8'h1E);
		repeat (2) @(negedge core_clk);
		`SMOP_CHK("irq", 1'b1, irq_seen)
		`SMOP_CHK("irq push", 3'd1, stack_level)
		`SMOP_CHK("interp", 1'b1, interp_en)
		for (i = 0; i < 2; i++) begin
			op(i ? 8'h2A : 8'h29);
			@(posedge core_clk);
			alu_operand <= 8'h80;
			frame_end <= 1'b1;
			@(posedge core_clk);
			frame_end <= 1'b0;
			@(negedge core_clk);
			`SMOP_CHK("ext", (i ? 10'h080 : 10'h380), alu_operand_ext)
		end
		`SMOP_CHK("interp off", 1'b0, interp_en)
		op(8'h2B);
		`SMOP_CHK("oe off", 8'h7E, port_b_pins.oe)
		@(posedge core_clk);
		pe6 = 0;
		repeat (320) @(posedge core_clk);
		`SMOP_CHK("clk16", 20, pe6)
		op(8'h27);
		op(8'h27);
		`SMOP_CHK("ext data", 8'hFF, acc[7:0])
		ser_en <= 1'b0;
		op(8'h2C);
		@(posedge core_clk);
		port_b_data <= 8'hA5;
		@(negedge core_clk);
		`SMOP_CHK("oe on", 8'hFF, port_b_pins.oe)
		`SMOP_CHK("pb out", 8'hA5, port_b_pins.out)
		rdr(4'h2);
		`SMOP_CHK("unmapped", 32'h0000_0000, rd)
		end_sim;
	end
	initial begin
		#800000;
		n_fail++;
		end_sim;
	end
endmodule : smop_exec_tb_top
